// file: include/pso_pkg.sv
package pso_pkg;
  // Register number of the key status and control word
  localparam logic [15:0] PSO_REG_KEYS_ADDR  = 16'h00F7;
  localparam int          PSO_KEY_COUNT      = 26;
  // Field positions
  localparam int          PSO_BIT_PROG       = 0;
  localparam int          PSO_BIT_DOWN       = 1;
  localparam int          PSO_BIT_UP         = 2;
  localparam int          PSO_BIT_LOCK_PROG  = 3;
  localparam int          PSO_BIT_LOCK_SP    = 4;
  localparam int          PSO_BIT_FKEY1      = 5;
  localparam int          PSO_BIT_FKEY5      = 9;
  localparam int          PSO_BIT_MODE       = 15;
  localparam int          PSO_BIT_DIGIT1     = 16;
  localparam int          PSO_BIT_DIGIT0     = 25;
  localparam int          PSO_REMOTE_BITS    = 8;
  // Implemented bits: 0..9, 15, 16..25; reserved read as zero
  localparam logic [31:0] PSO_IMPL_MASK      = 32'h03FF_83FF;
  localparam logic [31:0] PSO_KEY_MASK       = 32'h03FF_03FF;
  localparam logic        PSO_MODE_RESET     = 1'b0;
  localparam logic [31:0] PSO_SIM_RESET      = 32'h0000_0000;
  // Debounce time and its cycle count at 250 MHz
  localparam int          PSO_CLK_MHZ        = 250;
  localparam int          PSO_DEBOUNCE_US    = 10000;
  localparam int          PSO_DEBOUNCE_CYC   = PSO_DEBOUNCE_US * PSO_CLK_MHZ;
  localparam int          PSO_DB_CNT_W       = 22;
endpackage : pso_pkg

// file: src/pso_panel_switch_override.sv
`timescale 1ns/1ps
module pso_panel_switch_override #(
  parameter int DEBOUNCE_CYC = pso_pkg::PSO_DEBOUNCE_CYC,
  parameter logic [31:0] MODEL_MASK = pso_pkg::PSO_KEY_MASK
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [25:0] panel_pin,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             reg_ack,
  input  wire logic        editing_active,
  output logic      [25:0] key_to_firmware,
  output logic      [25:0] key_press_pulse,
  output logic      [2:0]  fkey_handler_pulse,
  output logic             remote_mode
);
  localparam int KN = pso_pkg::PSO_KEY_COUNT;

  logic          rst_s1;
  logic          rst_s2;
  logic [KN-1:0] pin_s1;
  logic [KN-1:0] pin_s2;
  logic [KN-1:0] deb;
  logic [KN-1:0] next_deb;
  logic [31:0]   sim;
  logic [31:0]   next_sim;
  logic          mode;
  logic          next_mode;
  logic [31:0]   rdata;
  logic [31:0]   next_rdata;
  logic          ack;
  logic          next_ack;
  logic [KN-1:0] fw;
  logic [KN-1:0] next_fw;
  logic [KN-1:0] press;
  logic [KN-1:0] next_press;
  logic [2:0]    fh;
  logic [2:0]    next_fh;
  logic [31:0]   key_word;
  logic [KN-1:0] deb_keys;
  logic [KN-1:0] sim_keys;
  logic          hit;
  logic          next_rst_s1;
  logic          next_rst_s2;
  logic [KN-1:0] next_pin_s1;
  logic [KN-1:0] next_pin_s2;
  logic          wr_hit;
  logic          rd_hit;
  logic          miss;
  logic [31:0]   read_word;
  logic [2:0]    fkey_press;

  // Reset release path: two stages so the rest sees a clean release
  always_comb begin
    next_rst_s1 = 1'b1;
    next_rst_s2 = rst_s1;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= next_rst_s1;
      rst_s2 <= next_rst_s2;
    end
  end

  // Panel contacts are asynchronous: two stages before any logic
  always_comb begin
    next_pin_s1 = panel_pin;
    next_pin_s2 = pin_s1;
  end

  always_ff @(posedge clk_sys or negedge rst_s2) begin
    if (!rst_s2) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= next_pin_s1;
      pin_s2 <= next_pin_s2;
    end
  end

  // Per-input debounce: accept a new level after it holds steady
  genvar g;
  generate
    for (g = 0; g < KN; g++) begin : g_deb
      logic [pso_pkg::PSO_DB_CNT_W-1:0] cnt;
      logic [pso_pkg::PSO_DB_CNT_W-1:0] next_cnt;
      always_comb begin
        next_cnt    = '0;
        next_deb[g] = deb[g];
        if (pin_s2[g] != deb[g]) begin
          if (int'(cnt) >= DEBOUNCE_CYC - 1) begin
            next_deb[g] = pin_s2[g];
          end else begin
            next_cnt = cnt + 1'b1;
          end
        end
      end
      always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2) begin
          cnt <= '0;
        end else begin
          cnt <= next_cnt;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_s2) begin
    if (!rst_s2) begin
      deb <= '0;
    end else begin
      deb <= next_deb;
    end
  end

  // Place debounced inputs into register layout
  always_comb begin
    key_word = '0;
    key_word[pso_pkg::PSO_BIT_PROG]      = deb[0];
    key_word[pso_pkg::PSO_BIT_DOWN]      = deb[1];
    key_word[pso_pkg::PSO_BIT_UP]        = deb[2];
    key_word[pso_pkg::PSO_BIT_LOCK_PROG] = deb[3];
    key_word[pso_pkg::PSO_BIT_LOCK_SP]   = deb[4];
    key_word[pso_pkg::PSO_BIT_FKEY5:pso_pkg::PSO_BIT_FKEY1] =
      deb[9:5];
    key_word[pso_pkg::PSO_BIT_DIGIT0:pso_pkg::PSO_BIT_DIGIT1] =
      deb[19:10];
    key_word = key_word & MODEL_MASK;
  end

  // Compact key order: register bits 0-9, then 16-25, top six unused
  always_comb begin
    deb_keys = {6'h00, key_word[25:16], key_word[9:0]};
    sim_keys = {6'h00, sim[25:16], sim[9:0]};
  end

  // Address decode; a write wins over a read in the same cycle
  always_comb begin
    hit    = (reg_addr == pso_pkg::PSO_REG_KEYS_ADDR);
    wr_hit = hit && reg_wr;
    rd_hit = hit && reg_rd && !reg_wr;
    miss   = !hit && (reg_wr || reg_rd);
  end

  // Read word: physical keys and mode only, host bits never read back
  always_comb begin
    read_word = key_word & pso_pkg::PSO_KEY_MASK;
    read_word[pso_pkg::PSO_BIT_MODE] = mode;
  end

  // Host-written state: mode bit and simulated keys
  always_comb begin
    next_sim  = sim;
    next_mode = mode;
    if (wr_hit) begin
      next_mode = reg_wdata[pso_pkg::PSO_BIT_MODE];
      next_sim  = reg_wdata & pso_pkg::PSO_KEY_MASK;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_s2) begin
    if (!rst_s2) begin
      sim  <= pso_pkg::PSO_SIM_RESET;
      mode <= pso_pkg::PSO_MODE_RESET;
    end else begin
      sim  <= next_sim;
      mode <= next_mode;
    end
  end

  // Every access is acknowledged; unmapped ones read zero
  always_comb begin
    next_ack   = wr_hit || rd_hit || miss;
    next_rdata = rdata;
    if (rd_hit) begin
      next_rdata = read_word;
    end else if (miss) begin
      next_rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_s2) begin
    if (!rst_s2) begin
      rdata <= '0;
      ack   <= 1'b0;
    end else begin
      rdata <= next_rdata;
      ack   <= next_ack;
    end
  end

  // Keys seen by firmware: in remote mode host bits replace bits 0-7;
  // host bits above that are stored but never reach the firmware
  genvar k;
  generate
    for (k = 0; k < KN; k++) begin : g_fw
      always_comb begin
        next_fw[k] = deb_keys[k];
        if (mode && (k < pso_pkg::PSO_REMOTE_BITS)) begin
          next_fw[k] = sim_keys[k];
        end
        next_press[k] = next_fw[k] && !fw[k];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_s2) begin
    if (!rst_s2) begin
      fw    <= '0;
      press <= '0;
    end else begin
      fw    <= next_fw;
      press <= next_press;
    end
  end

  // Handler pulses for function keys 1-3; editing swallows them,
  // while the status bit still shows the press
  always_comb begin
    fkey_press =
      next_press[pso_pkg::PSO_BIT_FKEY1+2:pso_pkg::PSO_BIT_FKEY1];
    next_fh = 3'h0;
    if (!editing_active) begin
      next_fh = fkey_press;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_s2) begin
    if (!rst_s2) begin
      fh <= 3'h0;
    end else begin
      fh <= next_fh;
    end
  end

  assign reg_rdata          = rdata;
  assign reg_ack            = ack;
  assign key_to_firmware    = fw;
  assign key_press_pulse    = press;
  assign fkey_handler_pulse = fh;
  assign remote_mode        = mode;
endmodule : pso_panel_switch_override

// file: verification/pso_panel_model.sv
`timescale 1ns/1ps
module pso_panel_model (
  input  wire logic        clk_sys,
  input  wire logic [25:0] press,
  output logic      [25:0] panel_pin
);
  initial panel_pin = 26'h0;
  // Contacts move just after an edge, never on it
  always @(posedge clk_sys) panel_pin <= press;
endmodule : pso_panel_model

// file: verification/pso_panel_switch_override_chk.sv
`timescale 1ns/1ps
module pso_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic editing_active,
  input wire logic [25:0] key_to_firmware,
  input wire logic [25:0] key_press_pulse,
  input wire logic [2:0] fkey_handler_pulse,
  input wire logic remote_mode
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_wr;
    reg_wr && reg_addr == 16'h00F7;
  endsequence
  a_ack_after: assert property (reg_wr || reg_rd |=> reg_ack)
    else $error("ack missing");
  a_rsvd_zero: assert property (reg_ack |->
    (reg_rdata & ~pso_pkg::PSO_IMPL_MASK) == 32'h0)
    else $error("reserved bit set");
  a_mode_write: assert property (s_wr |=>
    remote_mode == $past(reg_wdata[15]))
    else $error("mode not written");
  a_mode_read: assert property (reg_rd && !reg_wr && reg_addr == 16'h00F7
    |=> reg_rdata[15] == $past(remote_mode))
    else $error("mode not read");
  a_press_edge: assert property (key_press_pulse ==
    (key_to_firmware & ~$past(key_to_firmware)))
    else $error("press pulse wrong");
  a_fkey_cause: assert property (fkey_handler_pulse != 3'h0 |->
    (key_press_pulse[7:5] & fkey_handler_pulse) == fkey_handler_pulse)
    else $error("handler without press");
  a_fkey_edit: assert property (editing_active && $past(editing_active)
    |-> fkey_handler_pulse == 3'h0)
    else $error("handler while editing");
  a_remote_hold: assert property (remote_mode && $past(remote_mode, 2)
    && !$past(reg_wr) && !$past(reg_wr, 2)
    |-> $stable(key_to_firmware[7:0]))
    else $error("panel leaked in remote");
endmodule : pso_chk
bind pso_panel_switch_override pso_chk u_chk (.*);

// file: verification/pso_panel_switch_override_test.sv
`timescale 1ns/1ps
module pso_panel_switch_override_test;
  logic clk_sys, rst_n, reg_wr, reg_rd, editing_active, reg_ack, remote_mode;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [25:0] press, panel_pin, key_to_firmware, key_press_pulse;
  logic [2:0]  fkey_handler_pulse;
  int          n_mismatch, check_count, n_fk;
  pso_panel_model u_pm (.*);
  pso_panel_switch_override #(.DEBOUNCE_CYC(4)) u_dut (.*);
  initial begin
    clk_sys = 0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) if (fkey_handler_pulse != 3'h0) n_fk++;
  task automatic w(int n);
    repeat (n) @(posedge clk_sys);
  endtask : w
  task automatic chk(logic [31:0] g, logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= 16'h00F7;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    w(2);
  endtask : wr
  task automatic rd(logic [15:0] a, logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
    chk(32'(reg_ack), 32'h1);
  endtask : rd
  task automatic rst();
    rst_n <= 1'b0;
    w(20);
    rst_n <= 1'b1;
    w(3);
  endtask : rst
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  initial begin
    #20000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    {rst_n, reg_wr, reg_rd, editing_active} = 4'h0;
    {reg_addr, reg_wdata, press} = 74'h0;
    {n_fk, n_mismatch, check_count} = 96'h0;
    rst();
    rd(16'h00F7, 32'h0);
    rd(16'h00F6, 32'h0);
    for (int i = 0; i < 20; i++) begin
      press <= 26'h3F00000 | (26'h1 << i);
      w(12);
      rd(16'h00F7, 32'h1 << (i < 10 ? i : i + 6));
    end
    chk(n_fk, 32'h3);
    editing_active <= 1'b1;
    press <= 26'h20;
    w(12);
    rd(16'h00F7, 32'h20);
    chk(n_fk, 32'h3);
    editing_active <= 1'b0;
    wr(32'h0000_8000);
    chk(32'(remote_mode), 32'h1);
    press <= 26'h1;
    w(12);
    rd(16'h00F7, 32'h0000_8001);
    chk(32'(key_to_firmware), 32'h0);
    wr(32'h0000_8021);
    chk(32'(key_to_firmware), 32'h21);
    chk(n_fk, 32'h4);
    wr(32'h0000_8000);
    chk(32'(key_to_firmware), 32'h0);
    wr(32'h0);
    wr(32'h0000_8000);
    rst();
    w(12);
    rd(16'h00F7, 32'h1);
    chk(32'(key_to_firmware), 32'h1);
    print_verdict();
  end
endmodule : pso_panel_switch_override_test
